// >>> logic/ufl_params.svh
`ifndef UFL_PARAMS_SVH
`define UFL_PARAMS_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define UFL_ADDR_TFL 32'h5000_1080
`define UFL_ADDR_RFL 32'h5000_1084
`define UFL_ADDR_SRR 32'h5000_1088
`define UFL_ADDR_SRTS 32'h5000_108c
// ----------------------------------------
// field positions and widths
// ----------------------------------------
`define UFL_LVL_W 5
`define UFL_SRR_TXF_BIT 2
`define UFL_SRR_RXF_BIT 1
`define UFL_SRR_UR_BIT 0
`define UFL_SRTS_BIT 0
// ----------------------------------------
// reset values and timing counts
// ----------------------------------------
`define UFL_LVL_RST 5'h00
`define UFL_RDATA_RST 32'h0000_0000
`define UFL_RTS_RST 1'h0
`define UFL_URST_W 2
`define UFL_URST_CYCLES 2'h2
`define UFL_FIFO_DEPTH 16
`endif

// >>> logic/ufl_pkg.sv
`include "ufl_params.svh"
package ufl_pkg;
    // state of the register front end
    typedef struct packed {
        logic [31:0] rdata;
        logic slverr;
        logic rts_bit;
        logic tx_flush;
        logic rx_flush;
        logic [`UFL_URST_W-1:0] ur_cnt;
    } ufl_regs_type;
    // state of one fill-level counter
    typedef struct packed {
        logic [`UFL_LVL_W-1:0] count;
    } ufl_cnt_type;
    // state of the flow-control output stage
    typedef struct packed {
        logic rts_n;
        logic loop_rts;
    } ufl_rts_type;
endpackage

// >>> logic/ufl_level_cnt.sv
`timescale 1ns/1ps
`include "ufl_params.svh"
module ufl_level_cnt
    import ufl_pkg::*;
#(
    parameter int DEPTH = `UFL_FIFO_DEPTH
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic push,
    input wire logic pop,
    input wire logic flush,
    output logic [`UFL_LVL_W-1:0] level
);
    // a full fifo must still fit the five-bit level field
    initial
    begin
        if (DEPTH < 1 || DEPTH > 31)
            $error("ufl_level_cnt: depth out of range");
    end

    localparam logic [`UFL_LVL_W-1:0] FULL = DEPTH[`UFL_LVL_W-1:0];

    a_level_push_step: assert property (@(posedge clk) disable iff (rst)
        ce && push && !pop && !flush && level != FULL |=> level == $past(level) + 5'h01)
        else $error("level did not count a push");

    ufl_cnt_type r;
    ufl_cnt_type next_r;

    // flush beats a push in the same cycle so the fifo really reads empty
    always_comb
    begin
        next_r = r;
        if (flush)
            next_r.count = `UFL_LVL_RST;
        else if (push && !pop && r.count != FULL)
            next_r.count = r.count + 5'h01;
        else if (pop && !push && r.count != `UFL_LVL_RST)
            next_r.count = r.count - 5'h01;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            r.count <= `UFL_LVL_RST;
        else if (ce)
            r <= next_r;
    end

    assign level = r.count;

    a_level_flush_zero: assert property (@(posedge clk) disable iff (rst)
        ce && flush |=> level == `UFL_LVL_RST)
        else $error("level not zero after flush");
    a_level_in_range: assert property (@(posedge clk) disable iff (rst)
        level <= FULL)
        else $error("level above fifo depth");
endmodule

// >>> logic/ufl_rts_ctrl.sv
`timescale 1ns/1ps
module ufl_rts_ctrl
    import ufl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic rts_bit,
    input wire logic auto_flow_option,
    input wire logic fifo_en,
    input wire logic loopback,
    input wire logic rx_above_trig,
    output logic rts_n,
    output logic loop_rts
);
    ufl_rts_type r;
    ufl_rts_type next_r;

    // priority: loopback, then threshold throttle, then the stored bit
    always_comb
    begin
        next_r = r;
        next_r.loop_rts = rts_bit;
        if (loopback)
            next_r.rts_n = 1'b1;
        else if (auto_flow_option && fifo_en && rx_above_trig)
            next_r.rts_n = 1'b1;
        else
            next_r.rts_n = !rts_bit;
    end

    // rts_n idles inactive high so the modem never sees a false ready
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            r.rts_n <= 1'b1;
            r.loop_rts <= 1'b0;
        end
        else if (ce)
            r <= next_r;
    end

    assign rts_n = r.rts_n;
    assign loop_rts = r.loop_rts;

    a_rts_plain_follow: assert property (@(posedge clk) disable iff (rst)
        ce && !loopback && !auto_flow_option |=> rts_n == !$past(rts_bit))
        else $error("rts_n does not follow stored bit");
    a_rts_auto_throttle: assert property (@(posedge clk) disable iff (rst)
        ce && !loopback && auto_flow_option && fifo_en && rx_above_trig |=> rts_n)
        else $error("rts_n not throttled above trigger");
    a_rts_auto_follow: assert property (@(posedge clk) disable iff (rst)
        ce && !loopback && auto_flow_option && !rx_above_trig
        |=> rts_n == !$past(rts_bit))
        else $error("rts_n ignores stored bit under auto flow");
    a_rts_loop_hold: assert property (@(posedge clk) disable iff (rst)
        ce && loopback |=> rts_n && loop_rts == $past(rts_bit))
        else $error("loopback rts handling wrong");
endmodule

// >>> logic/ufl_ctrl.sv
`timescale 1ns/1ps
`include "ufl_params.svh"
module ufl_ctrl
    import ufl_pkg::*;
#(
    parameter int TX_DEPTH = `UFL_FIFO_DEPTH,
    parameter int RX_DEPTH = `UFL_FIFO_DEPTH
)
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic TX_PUSH,
    input wire logic TX_POP,
    input wire logic RX_PUSH,
    input wire logic RX_POP,
    input wire logic MCW_RTS_WE,
    input wire logic MCW_RTS_BIT,
    input wire logic AUTO_FLOW_OPTION,
    input wire logic FIFO_EN,
    input wire logic LOOPBACK,
    input wire logic RX_ABOVE_TRIG,
    output logic MIRRORED_SEND_REQUEST,
    output logic RTS_N,
    output logic LOOP_RTS,
    output logic TX_QUEUE_FLUSH,
    output logic RX_QUEUE_FLUSH,
    output logic PORT_SOFT_RESET
);
    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    logic setup;
    logic acc_wr;
    logic hit_tfl;
    logic hit_rfl;
    logic hit_srr;
    logic hit_srts;
    logic hit_any;
    logic rd_setup;
    logic srr_ur_wr;
    logic soft_rst;
    logic tx_flush_now;
    logic rx_flush_now;
    logic [`UFL_LVL_W-1:0] tx_level;
    logic [`UFL_LVL_W-1:0] rx_level;

    ufl_regs_type r;
    ufl_regs_type next_r;

    // both depths must fit the five-bit level fields
    if (TX_DEPTH < 1 || TX_DEPTH > 31 || RX_DEPTH < 1 || RX_DEPTH > 31)
    begin : g_depth_check
        $error("ufl_ctrl: fifo depth out of range");
    end

    // address compare on the full word; anything else is unmapped
    assign hit_tfl = PADDR == `UFL_ADDR_TFL;
    assign hit_rfl = PADDR == `UFL_ADDR_RFL;
    assign hit_srr = PADDR == `UFL_ADDR_SRR;
    assign hit_srts = PADDR == `UFL_ADDR_SRTS;
    assign setup = PSEL && !PENABLE;
    assign acc_wr = PSEL && PENABLE && PWRITE;
    assign hit_any = hit_tfl || hit_rfl || hit_srr || hit_srts;
    assign rd_setup = CE && setup && !PWRITE;

    // port reset strobe fires in the write cycle itself, not a cycle later
    assign srr_ur_wr = acc_wr && hit_srr && PWDATA[`UFL_SRR_UR_BIT];
    assign soft_rst = r.ur_cnt != `UFL_URST_W'(0);

    // flushes act on the level counters straight away; port reset flushes both
    assign tx_flush_now = (acc_wr && hit_srr && PWDATA[`UFL_SRR_TXF_BIT]) || soft_rst;
    assign rx_flush_now = (acc_wr && hit_srr && PWDATA[`UFL_SRR_RXF_BIT]) || soft_rst;

    // ----------------------------------------
    // register next state
    // ----------------------------------------
    // read data is captured in the setup cycle so the access phase needs
    // no wait state; the level seen is the one at the setup edge
    always_comb
    begin
        next_r = r;
        next_r.tx_flush = 1'b0;
        next_r.rx_flush = 1'b0;
        if (soft_rst)
            next_r.ur_cnt = r.ur_cnt - `UFL_URST_W'(1);
        if (!PSEL)
            next_r.slverr = 1'b0;
        if (setup)
        begin
            next_r.rdata = `UFL_RDATA_RST;
            next_r.slverr = !hit_any;
            if (!PWRITE && hit_tfl)
                next_r.rdata[`UFL_LVL_W-1:0] = tx_level;
            else if (!PWRITE && hit_rfl)
                next_r.rdata[`UFL_LVL_W-1:0] = rx_level;
            else if (!PWRITE && hit_srts)
                next_r.rdata[`UFL_SRTS_BIT] = r.rts_bit;
        end
        // strobe bits are write-only; flush bits are held one cycle, the reset bit loads a two-cycle count, never placed in read data, so they read as zero
        if (acc_wr && hit_srr)
        begin
            next_r.tx_flush = PWDATA[`UFL_SRR_TXF_BIT];
            next_r.rx_flush = PWDATA[`UFL_SRR_RXF_BIT];
            if (PWDATA[`UFL_SRR_UR_BIT])
                next_r.ur_cnt = `UFL_URST_CYCLES;
        end
        // one stored bit for both write paths; the bus write wins a tie
        if (acc_wr && hit_srts)
            next_r.rts_bit = PWDATA[`UFL_SRTS_BIT];
        else if (MCW_RTS_WE)
            next_r.rts_bit = MCW_RTS_BIT;
        if (soft_rst)
            next_r.rts_bit = `UFL_RTS_RST;
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            r.rdata <= `UFL_RDATA_RST;
            r.slverr <= 1'b0;
            r.rts_bit <= `UFL_RTS_RST;
            r.tx_flush <= 1'b0;
            r.rx_flush <= 1'b0;
            r.ur_cnt <= `UFL_URST_W'(0);
        end
        else if (CE)
            r <= next_r;
    end

    // ----------------------------------------
    // level counters and flow-control stage
    // ----------------------------------------
    ufl_level_cnt #(
        .DEPTH(TX_DEPTH)
    ) u_tx_level (
        .clk(CLK),
        .rst(RST),
        .ce(CE),
        .push(TX_PUSH),
        .pop(TX_POP),
        .flush(tx_flush_now),
        .level(tx_level)
    );

    ufl_level_cnt #(
        .DEPTH(RX_DEPTH)
    ) u_rx_level (
        .clk(CLK),
        .rst(RST),
        .ce(CE),
        .push(RX_PUSH),
        .pop(RX_POP),
        .flush(rx_flush_now),
        .level(rx_level)
    );

    ufl_rts_ctrl u_rts (
        .clk(CLK),
        .rst(RST || soft_rst),
        .ce(CE),
        .rts_bit(r.rts_bit),
        .auto_flow_option(AUTO_FLOW_OPTION),
        .fifo_en(FIFO_EN),
        .loopback(LOOPBACK),
        .rx_above_trig(RX_ABOVE_TRIG),
        .rts_n(RTS_N),
        .loop_rts(LOOP_RTS)
    );

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // zero-wait slave: every access completes in its first access cycle
    assign PREADY = 1'b1;
    assign PRDATA = r.rdata;
    assign PSLVERR = r.slverr && PSEL && PENABLE;
    assign MIRRORED_SEND_REQUEST = r.rts_bit;
    assign TX_QUEUE_FLUSH = r.tx_flush;
    assign RX_QUEUE_FLUSH = r.rx_flush;
    // one reset line feeds both clock domains; the serial side must
    // resynchronise its release, since this end only spans the bus clock
    assign PORT_SOFT_RESET = srr_ur_wr || soft_rst;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_srr_write(int b);
        CE && acc_wr && hit_srr && PWDATA[b];
    endsequence

    sequence s_reset_stretch;
        PORT_SOFT_RESET [*3];
    endsequence

    // read data must be the level seen at the setup edge, upper bits zero
    a_tx_level_read: assert property (@(posedge CLK) disable iff (RST)
        CE && setup && !PWRITE && hit_tfl
        |=> PRDATA == {27'h0, $past(tx_level)})
        else $error("transmit level read wrong");
    a_rx_level_read: assert property (@(posedge CLK) disable iff (RST)
        CE && setup && !PWRITE && hit_rfl
        |=> PRDATA == {27'h0, $past(rx_level)})
        else $error("receive level read wrong");
    // a flush empties the level at once and lasts a single cycle
    a_tx_flush_pulse: assert property (@(posedge CLK) disable iff (RST)
        s_srr_write(`UFL_SRR_TXF_BIT) |=> TX_QUEUE_FLUSH && tx_level == `UFL_LVL_RST
        ##1 !TX_QUEUE_FLUSH)
        else $error("transmit flush not single pulse");
    a_rx_flush_pulse: assert property (@(posedge CLK) disable iff (RST)
        s_srr_write(`UFL_SRR_RXF_BIT) |=> RX_QUEUE_FLUSH && rx_level == `UFL_LVL_RST
        ##1 !RX_QUEUE_FLUSH)
        else $error("receive flush not single pulse");
    // the port reset shows in the write cycle and stretches two more cycles
    a_port_reset_now: assert property (@(posedge CLK) disable iff (RST)
        s_srr_write(`UFL_SRR_UR_BIT) |-> s_reset_stretch ##1 !PORT_SOFT_RESET)
        else $error("port reset timing wrong");
    a_port_reset_both: assert property (@(posedge CLK) disable iff (RST)
        CE && soft_rst |-> PORT_SOFT_RESET ##1 tx_level == `UFL_LVL_RST
        && rx_level == `UFL_LVL_RST && MIRRORED_SEND_REQUEST == `UFL_RTS_RST)
        else $error("port reset does not reach all logic");
    // either write path lands in the one stored bit
    a_rts_bus_mirror: assert property (@(posedge CLK) disable iff (RST)
        CE && acc_wr && hit_srts && !soft_rst
        |=> MIRRORED_SEND_REQUEST == $past(PWDATA[`UFL_SRTS_BIT]))
        else $error("shadow write not stored");
    a_rts_mcw_mirror: assert property (@(posedge CLK) disable iff (RST)
        CE && MCW_RTS_WE && !(acc_wr && hit_srts) && !soft_rst
        |=> MIRRORED_SEND_REQUEST == $past(MCW_RTS_BIT))
        else $error("modem control write not stored");
    // with no pushes after a flush the level must not creep up
    a_level_stays_zero: assert property (@(posedge CLK) disable iff (RST)
        CE && tx_flush_now ##1 (!TX_PUSH || !CE) [*2] |-> tx_level == `UFL_LVL_RST)
        else $error("level rose without new entries");

    // ----------------------------------------
    // bus response checks
    // ----------------------------------------
    // a stale error flag from an earlier access is the easy slip here
    a_unmapped_error: assert property (@(posedge CLK) disable iff (RST)
        CE && setup && !hit_any |=> PSLVERR && PRDATA == `UFL_RDATA_RST)
        else $error("unmapped access not refused");
    a_mapped_no_error: assert property (@(posedge CLK) disable iff (RST)
        CE && setup && hit_any |=> !PSLVERR)
        else $error("mapped access flagged as error");
    // write-only strobes must never leak back as read data
    a_srr_reads_zero: assert property (@(posedge CLK) disable iff (RST)
        rd_setup && hit_srr |=> PRDATA == `UFL_RDATA_RST)
        else $error("strobe register read not zero");
    a_srts_read_back: assert property (@(posedge CLK) disable iff (RST)
        rd_setup && hit_srts
        |=> PRDATA == {31'h0, $past(MIRRORED_SEND_REQUEST)})
        else $error("shadow bit read back wrong");
    // the level registers ignore bus writes entirely
    a_tx_read_only: assert property (@(posedge CLK) disable iff (RST)
        CE && acc_wr && hit_tfl && !TX_PUSH && !TX_POP && !tx_flush_now
        |=> $stable(tx_level))
        else $error("write reached the transmit level");
    a_rx_read_only: assert property (@(posedge CLK) disable iff (RST)
        CE && acc_wr && hit_rfl && !RX_PUSH && !RX_POP && !rx_flush_now
        |=> $stable(rx_level))
        else $error("write reached the receive level");

    // ----------------------------------------
    // strobe and stored bit checks
    // ----------------------------------------
    // a held flush strobe would keep the fifos empty for good
    a_flush_self_clear: assert property (@(posedge CLK) disable iff (RST)
        CE && !(acc_wr && hit_srr) |=> !TX_QUEUE_FLUSH && !RX_QUEUE_FLUSH)
        else $error("flush strobe did not clear itself");
    // the stored bit moves only through its two write paths or a port reset
    a_mirror_holds: assert property (@(posedge CLK) disable iff (RST)
        CE && !(acc_wr && hit_srts) && !MCW_RTS_WE && !soft_rst
        |=> $stable(MIRRORED_SEND_REQUEST))
        else $error("stored request bit changed unasked");
    // the request line goes idle while the port reset runs
    a_rts_reset_idle: assert property (@(posedge CLK) disable iff (RST)
        CE && soft_rst |=> RTS_N)
        else $error("request line active during port reset");
endmodule

// >>> testbench/ufl_modem_model.sv
`timescale 1ns/1ps
module ufl_modem_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic rts_n,
    input wire logic go,
    output logic rx_push
);
    // ----------------------------------------
    // far-side modem
    // ----------------------------------------
    // sends one character a cycle while asked to and the port is ready;
    // a high request line stops it from the next cycle, so throttling is visible
    always_ff @(posedge clk)
    begin
        rx_push <= go && !rts_n && !rst;
    end
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`include "ufl_params.svh"
module testbench;
    import ufl_pkg::*;
    logic clk, rst, ce, psel, penable, pwrite, pready, pslverr, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic tx_push, tx_pop, rx_push, rx_pop, mcw_we, mcw_bit, go;
    logic auto_flow, fifo_en, loopback, above, mirr, rts_n, loop_rts, txf, rxf, psr;
    int n_mismatch = 0;
    int checks_done = 0;
    int nwait = 0;
    ufl_ctrl ufl_ctrl_inst (.CLK(clk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .TX_PUSH(tx_push), .TX_POP(tx_pop), .RX_PUSH(rx_push),
        .RX_POP(rx_pop), .MCW_RTS_WE(mcw_we), .MCW_RTS_BIT(mcw_bit),
        .AUTO_FLOW_OPTION(auto_flow), .FIFO_EN(fifo_en), .LOOPBACK(loopback),
        .RX_ABOVE_TRIG(above), .MIRRORED_SEND_REQUEST(mirr), .RTS_N(rts_n),
        .LOOP_RTS(loop_rts), .TX_QUEUE_FLUSH(txf), .RX_QUEUE_FLUSH(rxf),
        .PORT_SOFT_RESET(psr));
    ufl_modem_model ufl_modem_model_inst (.clk(clk), .rst(rst), .rts_n(rts_n), .go(go),
        .rx_push(rx_push));
    // ----------------------------------------
    // clock and watchdog
    // ----------------------------------------
    // free-running 200 MHz bus clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // the tests need under two hundred cycles; over fifteen times that means a hang
    initial
    begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; the request is held until pready is seen high
    task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        nwait = -1;
        // only the watchdog ends a wait that never sees pready
        do
        begin
            @(posedge clk);
            nwait++;
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp, input logic e);
        apb(1'b0, addr, 32'h0);
        chk_word(rd, exp);
        chk_bit(err, e);
        chk_word(32'(nwait), 32'h0);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic drive_lvl(input logic tp, input logic tq, input logic rq, input int n);
        @(posedge clk);
        tx_push <= tp;
        tx_pop <= tq;
        rx_pop <= rq;
        repeat (n) @(posedge clk);
        tx_push <= 1'b0;
        tx_pop <= 1'b0;
        rx_pop <= 1'b0;
    endtask
    task automatic modem(input int n);
        @(posedge clk);
        go <= 1'b1;
        repeat (n) @(posedge clk);
        go <= 1'b0;
        wait_cyc(3);
    endtask
    task automatic set_mode(input logic a, input logic f, input logic l, input logic t);
        @(posedge clk);
        auto_flow <= a;
        fifo_en <= f;
        loopback <= l;
        above <= t;
        wait_cyc(2);
    endtask
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial
    begin
        {rst, ce} = 2'b11;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {tx_push, tx_pop, rx_pop, mcw_we, mcw_bit, go} = '0;
        {auto_flow, fifo_en, loopback, above} = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd_chk(`UFL_ADDR_TFL, 32'h0, 1'b0);
        rd_chk(`UFL_ADDR_RFL, 32'h0, 1'b0);
        rd_chk(`UFL_ADDR_SRR, 32'h0, 1'b0);
        rd_chk(`UFL_ADDR_SRTS, 32'h0, 1'b0);
        chk_bit(rts_n, 1'b1);
        rd_chk(32'h5000_1090, 32'h0, 1'b1);
        apb(1'b1, `UFL_ADDR_TFL, 32'h1f);
        rd_chk(`UFL_ADDR_TFL, 32'h0, 1'b0);
        apb(1'b1, `UFL_ADDR_RFL, 32'h1f);
        rd_chk(`UFL_ADDR_RFL, 32'h0, 1'b0);
        // overfill, then one pop; the count saturates at the depth
        drive_lvl(1'b1, 1'b0, 1'b0, 20);
        rd_chk(`UFL_ADDR_TFL, 32'(`UFL_FIFO_DEPTH), 1'b0);
        drive_lvl(1'b0, 1'b1, 1'b0, 1);
        rd_chk(`UFL_ADDR_TFL, 32'(`UFL_FIFO_DEPTH - 1), 1'b0);
        // pushes with the clock enable low must not count
        @(posedge clk);
        ce <= 1'b0;
        tx_push <= 1'b1;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        tx_push <= 1'b0;
        rd_chk(`UFL_ADDR_TFL, 32'(`UFL_FIFO_DEPTH - 1), 1'b0);
        apb(1'b1, `UFL_ADDR_SRR, 32'h4);
        #1;
        chk_bit(txf, 1'b1);
        chk_bit(rxf, 1'b0);
        wait_cyc(1);
        chk_bit(txf, 1'b0);
        rd_chk(`UFL_ADDR_TFL, 32'h0, 1'b0);
        apb(1'b1, `UFL_ADDR_SRTS, 32'h1);
        wait_cyc(2);
        chk_bit(mirr, 1'b1);
        chk_bit(rts_n, 1'b0);
        rd_chk(`UFL_ADDR_SRTS, 32'h1, 1'b0);
        modem(5);
        rd_chk(`UFL_ADDR_RFL, 32'h5, 1'b0);
        set_mode(1'b1, 1'b1, 1'b0, 1'b1);
        chk_bit(rts_n, 1'b1);
        modem(4);
        rd_chk(`UFL_ADDR_RFL, 32'h5, 1'b0);
        set_mode(1'b1, 1'b1, 1'b0, 1'b0);
        chk_bit(rts_n, 1'b0);
        set_mode(1'b1, 1'b0, 1'b0, 1'b1);
        chk_bit(rts_n, 1'b0);
        set_mode(1'b0, 1'b0, 1'b0, 1'b0);
        drive_lvl(1'b0, 1'b0, 1'b1, 2);
        rd_chk(`UFL_ADDR_RFL, 32'h3, 1'b0);
        apb(1'b1, `UFL_ADDR_SRR, 32'h2);
        #1;
        chk_bit(rxf, 1'b1);
        chk_bit(txf, 1'b0);
        rd_chk(`UFL_ADDR_RFL, 32'h0, 1'b0);
        // modem control word path clears the same stored bit
        @(posedge clk);
        mcw_we <= 1'b1;
        @(posedge clk);
        mcw_we <= 1'b0;
        wait_cyc(2);
        chk_bit(mirr, 1'b0);
        chk_bit(rts_n, 1'b1);
        rd_chk(`UFL_ADDR_SRTS, 32'h0, 1'b0);
        // and sets it again, so the written value really is taken
        @(posedge clk);
        {mcw_we, mcw_bit} <= 2'b11;
        @(posedge clk);
        {mcw_we, mcw_bit} <= 2'b00;
        wait_cyc(2);
        chk_bit(mirr, 1'b1);
        chk_bit(rts_n, 1'b0);
        apb(1'b1, `UFL_ADDR_SRTS, 32'h1);
        set_mode(1'b0, 1'b0, 1'b1, 1'b0);
        chk_bit(rts_n, 1'b1);
        chk_bit(loop_rts, 1'b1);
        set_mode(1'b0, 1'b0, 1'b0, 1'b0);
        drive_lvl(1'b1, 1'b0, 1'b0, 3);
        apb(1'b1, `UFL_ADDR_SRR, 32'h1);
        #1;
        chk_bit(psr, 1'b1);
        wait_cyc(2);
        chk_bit(psr, 1'b0);
        chk_bit(rts_n, 1'b1);
        rd_chk(`UFL_ADDR_TFL, 32'h0, 1'b0);
        rd_chk(`UFL_ADDR_SRTS, 32'h0, 1'b0);
        test_done();
    end
endmodule
